// *** hw/dofs_link_mon.sv ***
`timescale 1ns/1ps

module dofs_link_mon (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Connection present
    input wire logic link_up,
    // Connection state
    output wire logic link_idle,
    output wire logic link_run,
    output wire logic link_lost,
    output wire logic loss_event
);

    // Current and next state
    dofs_pkg::dofs_link_state_type state;
    dofs_pkg::dofs_link_state_type next_state;

    // Next state from the connection level
    always_comb begin
        next_state = state;
        case (state)
            // No connection seen since reset
            dofs_pkg::DOFS_ST_IDLE: begin
                if (link_up) begin
                    next_state = dofs_pkg::DOFS_ST_RUN;
                end
            end
            // Connection established
            dofs_pkg::DOFS_ST_RUN: begin
                if (!link_up) begin
                    next_state = dofs_pkg::DOFS_ST_LOST;
                end
            end
            // Connection dropped, wait for it to return
            dofs_pkg::DOFS_ST_LOST: begin
                if (link_up) begin
                    next_state = dofs_pkg::DOFS_ST_RUN;
                end
            end
            // Illegal code falls back to a safe start
            default: begin
                next_state = dofs_pkg::DOFS_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= dofs_pkg::DOFS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Decoded state flags
    assign link_idle = (state == dofs_pkg::DOFS_ST_IDLE);
    assign link_run = (state == dofs_pkg::DOFS_ST_RUN);
    assign link_lost = (state == dofs_pkg::DOFS_ST_LOST);
    // One pulse in the cycle the loss is seen
    assign loss_event = link_run && !link_up;

endmodule

// *** hw/dofs_pkg.sv ***
package dofs_pkg;

    // Point counts of the two module variants
    localparam int DOFS_POINTS_STD = 8;
    localparam int DOFS_POINTS_RED = 6;

    // Fail-safe choice per point
    typedef enum logic [1:0] {
        DOFS_FS_HOLD = 2'h0,
        DOFS_FS_RESET = 2'h1,
        DOFS_FS_SET = 2'h2
    } dofs_fs_type;

    // Settings of one output point
    typedef struct packed {
        logic sink_low_polarity;
        logic norm_closed;
        dofs_fs_type fail_mode;
    } dofs_cfg_type;

    // Value after reset: sourcing, normally open, reset output
    localparam dofs_cfg_type DOFS_CFG_RESET = '{
        sink_low_polarity: 1'h0,
        norm_closed: 1'h0,
        fail_mode: DOFS_FS_RESET
    };

    // Connection monitor states, one-hot
    typedef enum logic [2:0] {
        DOFS_ST_IDLE = 3'h1,
        DOFS_ST_RUN = 3'h2,
        DOFS_ST_LOST = 3'h4
    } dofs_link_state_type;

    // Connection loss counter
    localparam int DOFS_CNT_W = 8;
    localparam logic [DOFS_CNT_W-1:0] DOFS_CNT_RESET = 8'h00;
    localparam logic [DOFS_CNT_W-1:0] DOFS_CNT_MAX = 8'hFF;
    localparam logic [DOFS_CNT_W-1:0] DOFS_CNT_STEP = 8'h01;

endpackage

// *** hw/dofs_point.sv ***
`timescale 1ns/1ps

module dofs_point (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Settings and data
    input wire dofs_pkg::dofs_cfg_type cfg,
    input wire logic data_bit,
    // Substitution controls
    input wire logic fs_active,
    input wire logic force_off,
    // Field pin and status
    output logic pin_out,
    output logic pin_oe,
    output logic sig_on
);

    // Next values
    logic next_sig;
    logic next_pin_out;
    logic next_pin_oe;
    // Inverted data and fail-safe value
    logic logic_val;
    logic fs_val;

    // Inversion, substitution, then polarity mapping
    always_comb begin
        logic_val = cfg.norm_closed ? !data_bit : data_bit;
        case (cfg.fail_mode)
            dofs_pkg::DOFS_FS_HOLD: fs_val = sig_on;
            dofs_pkg::DOFS_FS_RESET: fs_val = 1'b0;
            dofs_pkg::DOFS_FS_SET: fs_val = 1'b1;
            // Unused code acts as the default reset choice
            default: fs_val = 1'b0;
        endcase
        if (force_off) begin
            next_sig = 1'b0;
        end else if (fs_active) begin
            next_sig = fs_val;
        end else begin
            next_sig = logic_val;
        end
        // Only the asserted state is driven; otherwise the pin floats
        next_pin_oe = next_sig;
        next_pin_out = next_sig && !cfg.sink_low_polarity;
    end

    // Output registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sig_on <= 1'b0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            sig_on <= next_sig;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end

endmodule

// *** hw/dofs_top.sv ***
`timescale 1ns/1ps

module dofs_top #(
    parameter int POINTS = dofs_pkg::DOFS_POINTS_STD
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Per-point settings
    input wire logic cfg_load,
    input wire dofs_pkg::dofs_cfg_type [POINTS-1:0] cfg_in,
    // Output data from the coupler
    input wire logic data_valid,
    input wire logic [POINTS-1:0] out_data,
    // Connection state from the coupler
    input wire logic link_up,
    input wire logic fault_mode_en,
    // Field pins
    output wire logic [POINTS-1:0] pin_out,
    output wire logic [POINTS-1:0] pin_oe,
    // Status
    output wire logic [POINTS-1:0] sig_on,
    output dofs_pkg::dofs_cfg_type [POINTS-1:0] cfg_cur,
    output wire logic link_lost,
    output logic failsafe_active,
    output logic [dofs_pkg::DOFS_CNT_W-1:0] loss_count
);

    // POINTS is 8 for the standard variant and 6 for the reduced one

    // Held settings, one entry per point
    dofs_pkg::dofs_cfg_type [POINTS-1:0] cfg_q;
    dofs_pkg::dofs_cfg_type [POINTS-1:0] next_cfg_q;

    // Latest accepted output data
    logic [POINTS-1:0] data_q;
    logic [POINTS-1:0] next_data_q;

    // Status registers
    logic next_failsafe_active;
    logic [dofs_pkg::DOFS_CNT_W-1:0] next_loss_count;

    // Connection monitor outputs
    logic link_idle;
    logic link_run;
    logic loss_event;

    // Fail-safe substitution request
    logic fs_now;

    // Connection monitor
    dofs_link_mon u_link_mon (
        .ref_clk(ref_clk),
        .rst(rst),
        .link_up(link_up),
        .link_idle(link_idle),
        .link_run(link_run),
        .link_lost(link_lost),
        .loss_event(loss_event)
    );

    // Substitution only when the coupler runs in fault mode
    assign fs_now = link_lost && fault_mode_en;

    // Settings load: every point takes its own entry
    always_comb begin
        next_cfg_q = cfg_q;
        if (cfg_load) begin
            next_cfg_q = cfg_in;
        end
    end

    // Settings register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= {POINTS{dofs_pkg::DOFS_CFG_RESET}};
        end else begin
            cfg_q <= next_cfg_q;
        end
    end

    // Data is accepted only while connected; stale data is kept otherwise
    always_comb begin
        next_data_q = data_q;
        if (data_valid && link_run) begin
            next_data_q = out_data;
        end
    end

    // Data register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_q <= '0;
        end else begin
            data_q <= next_data_q;
        end
    end

    // Loss counter saturates so it never wraps back to zero
    always_comb begin
        next_loss_count = loss_count;
        if (loss_event && (loss_count != dofs_pkg::DOFS_CNT_MAX)) begin
            next_loss_count = loss_count + dofs_pkg::DOFS_CNT_STEP;
        end
        next_failsafe_active = fs_now;
    end

    // Status registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            loss_count <= dofs_pkg::DOFS_CNT_RESET;
            failsafe_active <= 1'b0;
        end else begin
            loss_count <= next_loss_count;
            failsafe_active <= next_failsafe_active;
        end
    end

    // Settings readback straight from the held copy
    assign cfg_cur = cfg_q;

    // One conditioning stage per point
    genvar gi;
    generate
        for (gi = 0; gi < POINTS; gi = gi + 1) begin : g_point
            dofs_point u_point (
                .ref_clk(ref_clk),
                .rst(rst),
                .cfg(cfg_q[gi]),
                .data_bit(data_q[gi]),
                .fs_active(fs_now),
                .force_off(link_idle),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi]),
                .sig_on(sig_on[gi])
            );
        end
    endgenerate

    // Checks on the design's own outputs and internal registers
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Accepted update while connected
    sequence s_update;
        data_valid && link_run;
    endsequence

    // Connection drop seen in run state
    sequence s_drop;
        link_run && !link_up ##1 link_lost;
    endsequence

    // Data register takes the coupler word on an update
    a_data_capture: assert property (s_update |=> data_q == $past(out_data))
        else $error("data word not captured");

    // Data frozen while no connection
    a_data_frozen: assert property (!link_run |=> data_q == $past(data_q))
        else $error("data changed without connection");

    // Fault-mode gate on substitution
    a_fault_gate: assert property (s_drop |-> failsafe_active == 1'b0 ##1 failsafe_active == $past(fault_mode_en))
        else $error("fail-safe flag not following fault mode");

    // Loss without fault mode never raises the fail-safe flag
    a_no_fs_gate: assert property (!fault_mode_en |=> !failsafe_active)
        else $error("substitution without fault mode");

    // Connection back while lost
    sequence s_return;
        link_lost && link_up;
    endsequence

    // Drop in fault mode: loss entered with substitution armed
    sequence s_fs_entry;
        link_run && !link_up && fault_mode_en ##1 link_lost && fault_mode_en;
    endsequence

    // Monitor holds exactly one state code
    a_one_state: assert property ($onehot({link_idle, link_run, link_lost}))
        else $error("connection state not one-hot");

    // Drop in run state always enters loss
    a_loss_enter: assert property (link_run && !link_up |=> link_lost)
        else $error("connection drop not detected");

    // Loss lasts until the connection returns
    a_loss_stays: assert property (link_lost && !link_up |=> link_lost)
        else $error("loss state left without connection");

    // Returning connection resumes the data path
    a_loss_resume: assert property (s_return |=> link_run)
        else $error("connection return not seen");

    // Running state kept while connected
    a_run_stays: assert property (link_run && link_up |=> link_run)
        else $error("run state left while connected");

    // Idle until the first connection
    a_idle_stays: assert property (link_idle && !link_up |=> link_idle)
        else $error("idle state left without connection");

    // Nothing asserted before the first connection
    a_idle_off: assert property (link_idle |=> sig_on == '0 && pin_oe == '0)
        else $error("point asserted before first connection");

    // No data taken before the first connection
    a_idle_data: assert property (link_idle |-> data_q == '0)
        else $error("data taken before first connection");

    // Fail-safe flag follows substitution one cycle late
    a_fs_flag: assert property (fs_now |=> failsafe_active)
        else $error("fail-safe flag not raised");

    // Flag clears once the loss ends
    a_fs_clear: assert property (!link_lost |=> !failsafe_active)
        else $error("fail-safe flag without loss");

    // Fault-mode drop raises the flag two edges later
    a_fs_entry: assert property (s_fs_entry |=> failsafe_active)
        else $error("fail-safe flag late after drop");

    // Each loss adds one until the counter saturates
    a_loss_count: assert property (loss_event && loss_count != dofs_pkg::DOFS_CNT_MAX
                                   |=> loss_count == $past(loss_count) + dofs_pkg::DOFS_CNT_STEP)
        else $error("loss not counted");

    // Counter still without a new loss
    a_count_still: assert property (!loss_event |=> loss_count == $past(loss_count))
        else $error("loss counter moved without a loss");

    // Settings kept between loads
    a_cfg_keep: assert property (!cfg_load |=> cfg_q == $past(cfg_q))
        else $error("settings changed without a load");

    generate
        for (gi = 0; gi < POINTS; gi = gi + 1) begin : g_chk
            // Settings load per point
            a_cfg_load: assert property (cfg_load |=> cfg_q[gi] == $past(cfg_in[gi]))
                else $error("point settings not loaded");

            // Sourcing drive level
            a_src_high: assert property (pin_oe[gi] && !$past(cfg_q[gi].sink_low_polarity) |-> pin_out[gi])
                else $error("sourcing point not driven high");

            // Sinking drive level
            a_sink_low: assert property (pin_oe[gi] && $past(cfg_q[gi].sink_low_polarity) |-> !pin_out[gi])
                else $error("sinking point not driven low");

            // Drive enable tracks asserted signal
            a_oe_signal: assert property (pin_oe[gi] == sig_on[gi])
                else $error("drive enable differs from signal");

            // Normally open follows data one cycle later
            a_open_follow: assert property (!fs_now && !link_idle && !cfg_q[gi].norm_closed
                                            |=> sig_on[gi] == $past(data_q[gi]))
                else $error("normally open point not following data");

            // Normally closed inverts data
            a_closed_inv: assert property (!fs_now && !link_idle && cfg_q[gi].norm_closed
                                           |=> sig_on[gi] == !$past(data_q[gi]))
                else $error("normally closed point not inverting");

            // Hold keeps the last state over the whole loss
            a_hold_last: assert property (fs_now && cfg_q[gi].fail_mode == dofs_pkg::DOFS_FS_HOLD
                                          |=> $stable(sig_on[gi]))
                else $error("held point changed state");

            // Reset option turns the point off
            a_reset_off: assert property (fs_now && cfg_q[gi].fail_mode == dofs_pkg::DOFS_FS_RESET
                                          |=> !sig_on[gi] && !pin_oe[gi])
                else $error("reset point still asserted");

            // Set option turns the point on
            a_set_on: assert property (fs_now && cfg_q[gi].fail_mode == dofs_pkg::DOFS_FS_SET
                                       |=> sig_on[gi] && pin_oe[gi])
                else $error("set point not asserted");

            // Inactive point leaves its pin undriven
            a_pin_float: assert property (!sig_on[gi] |-> !pin_oe[gi] && !pin_out[gi])
                else $error("inactive point still drives its pin");

            // Unused fail-safe code acts as reset
            a_code_spare: assert property (fs_now && cfg_q[gi].fail_mode == 2'h3 |=> !sig_on[gi])
                else $error("spare fail-safe code asserted the point");

            // Without fault mode a lost point keeps following its data
            a_stale_follow: assert property (link_lost && !fault_mode_en
                                             |=> sig_on[gi] == $past(data_q[gi] ^ cfg_q[gi].norm_closed))
                else $error("point substituted without fault mode");
        end
    endgenerate

endmodule

// *** tb/dofs_coupler_model.sv ***
`timescale 1ns/1ps

module dofs_coupler_model #(
    parameter int POINTS = 8
) (
    // Clock
    input wire logic ref_clk,
    // Bench commands
    input wire logic send,
    input wire logic [POINTS-1:0] word,
    input wire logic conn,
    input wire logic fault_mode,
    // Coupler outputs
    output logic data_valid,
    output logic [POINTS-1:0] out_data,
    output logic link_up,
    output logic fault_mode_en
);
    // Commands latched on the rising edge, so bench and model never race
    logic s_q;
    logic [POINTS-1:0] w_q;
    logic c_q;
    logic f_q;

    // Quiet outputs at time zero
    initial begin
        data_valid = 1'b0;
        out_data = '0;
        link_up = 1'b0;
        fault_mode_en = 1'b0;
    end

    // Capture what the bench asks for
    always @(posedge ref_clk) begin
        s_q <= send;
        w_q <= word;
        c_q <= conn;
        f_q <= fault_mode;
    end

    // Drive on the falling edge; idle data toggles so stale bits never look valid
    always @(negedge ref_clk) begin
        data_valid <= s_q;
        out_data <= s_q ? w_q : ~out_data;
        link_up <= c_q;
        fault_mode_en <= f_q;
    end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    // Clock, reset and bench controls
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_load = 1'b0;
    dofs_pkg::dofs_cfg_type [7:0] cfg_in = '0;
    logic send = 1'b0;
    logic [7:0] word = 8'h00;
    logic conn = 1'b0;
    logic fault_mode = 1'b0;
    // Coupler side
    logic data_valid;
    logic [7:0] out_data;
    logic link_up;
    logic fault_mode_en;
    // Design outputs
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] sig_on;
    dofs_pkg::dofs_cfg_type [7:0] cfg_cur;
    logic link_lost;
    logic failsafe_active;
    logic [7:0] loss_count;
    // Six-point variant outputs
    logic [5:0] pin_out6;
    logic [5:0] pin_oe6;
    logic [5:0] sig_on6;
    dofs_pkg::dofs_cfg_type [5:0] cfg_cur6;
    // Tallies
    int n_mismatch = 0;
    int check_count = 0;
    localparam int WATCHDOG_CYCLES = 2000;

    // One ordinary case: settings, data, expected signal
    typedef struct {
        logic [31:0] cfg;
        logic [7:0] data;
        logic [7:0] sig;
    } dofs_row_type;
    // Mixed last row shows every point keeps its own settings
    dofs_row_type rows [4] = '{
        '{32'h11111111, 8'hA5, 8'hA5},
        '{32'h55555555, 8'hA5, 8'h5A},
        '{32'h99999999, 8'h3C, 8'h3C},
        '{32'hD519D519, 8'hF0, 8'h3C}
    };

    // Free-running 10 MHz clock
    always #50 ref_clk = ~ref_clk;

    dofs_coupler_model i_dofs_coupler_model (
        .ref_clk(ref_clk), .send(send), .word(word), .conn(conn), .fault_mode(fault_mode),
        .data_valid(data_valid), .out_data(out_data), .link_up(link_up), .fault_mode_en(fault_mode_en)
    );

    dofs_top i_dofs_top (
        .ref_clk(ref_clk), .rst(rst), .cfg_load(cfg_load), .cfg_in(cfg_in),
        .data_valid(data_valid), .out_data(out_data), .link_up(link_up),
        .fault_mode_en(fault_mode_en), .pin_out(pin_out), .pin_oe(pin_oe), .sig_on(sig_on),
        .cfg_cur(cfg_cur), .link_lost(link_lost), .failsafe_active(failsafe_active),
        .loss_count(loss_count)
    );

    // Reduced variant on the low six points of the same coupler
    dofs_top #(.POINTS(dofs_pkg::DOFS_POINTS_RED)) i_dofs_top_red (
        .ref_clk(ref_clk), .rst(rst), .cfg_load(cfg_load), .cfg_in(cfg_in[5:0]),
        .data_valid(data_valid), .out_data(out_data[5:0]), .link_up(link_up),
        .fault_mode_en(fault_mode_en), .pin_out(pin_out6), .pin_oe(pin_oe6), .sig_on(sig_on6),
        .cfg_cur(cfg_cur6), .link_lost(), .failsafe_active(), .loss_count()
    );

    // Wait on falling edges, where the bench changes inputs
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Compare and tally
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle settings load
    task automatic load(input logic [31:0] c);
        cfg_in = c;
        cfg_load = 1'b1;
        step(1);
        cfg_load = 1'b0;
    endtask

    // One data word through the coupler, then let it reach the pins
    task automatic push(input logic [7:0] d);
        word = d;
        send = 1'b1;
        step(1);
        send = 1'b0;
        step(5);
    endtask

    // Sink bit of every point
    function automatic logic [7:0] sink_mask(input logic [31:0] c);
        logic [7:0] m;
        for (int i = 0; i < 8; i++) begin
            m[i] = c[4*i+3];
        end
        return m;
    endfunction

    // Report and stop
    task automatic give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #(WATCHDOG_CYCLES * 100);
        n_mismatch++;
        give_verdict();
    end

    // Main sequence
    initial begin
        step(16);
        rst = 1'b0;
        step(2);
        chk(cfg_cur, 32'h11111111);
        chk(pin_oe, 8'h00);
        chk(loss_count, 8'h00);
        // Data before the first connection must not reach the pins
        push(8'hFF);
        chk(sig_on, 8'h00);
        $display("test reset done");
        conn = 1'b1;
        step(3);
        // Ordinary cases from the table
        foreach (rows[k]) begin
            load(rows[k].cfg);
            chk(cfg_cur, rows[k].cfg);
            push(rows[k].data);
            chk(sig_on, rows[k].sig);
            chk(pin_oe, rows[k].sig);
            chk(pin_out, rows[k].sig & ~sink_mask(rows[k].cfg));
            chk(cfg_cur6, rows[k].cfg[23:0]);
            chk(sig_on6, rows[k].sig[5:0]);
            chk(pin_out6, rows[k].sig[5:0] & ~sink_mask(rows[k].cfg));
            $display("test row %0d done", k);
        end
        // Loss with fault mode: hold, reset, set and code 3 side by side
        load(32'h32103210);
        fault_mode = 1'b1;
        push(8'h33);
        chk(sig_on, 8'h33);
        conn = 1'b0;
        step(5);
        chk(sig_on, 8'h55);
        chk(pin_out, 8'h55);
        chk(sig_on6, 6'h15);
        chk(link_lost, 1'b1);
        chk(failsafe_active, 1'b1);
        chk(loss_count, 8'h01);
        push(8'h00);
        chk(sig_on, 8'h55);
        $display("test fail-safe done");
        // Loss without fault mode leaves outputs on the last data
        conn = 1'b1;
        fault_mode = 1'b0;
        step(3);
        push(8'h0F);
        chk(sig_on, 8'h0F);
        chk(link_lost, 1'b0);
        conn = 1'b0;
        step(5);
        chk(sig_on, 8'h0F);
        chk(failsafe_active, 1'b0);
        chk(loss_count, 8'h02);
        $display("test no fault mode done");
        // Reset in mid-run
        rst = 1'b1;
        step(2);
        chk(sig_on, 8'h00);
        chk(cfg_cur, 32'h11111111);
        rst = 1'b0;
        step(2);
        chk(link_lost, 1'b0);
        chk(failsafe_active, 1'b0);
        chk(loss_count, 8'h00);
        chk(pin_oe, 8'h00);
        // First data after the second reset
        conn = 1'b1;
        step(3);
        push(8'hC3);
        chk(sig_on, 8'hC3);
        chk(pin_out, 8'hC3);
        chk(sig_on6, 6'h03);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule
